/* File: verilog/vec_irq_pkg.sv */
package vec_irq_pkg;
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] CPU_CONTROL_OFS = 8'h00; // vector base select and unlock
	localparam logic [7:0] SENSE_OFS = 8'h04; // external pin sense field
	localparam logic [7:0] ENABLE_OFS = 8'h08; // pin and group enables
	localparam logic [7:0] FLAG_OFS = 8'h0c; // sticky flags, write one to clear
	localparam logic [7:0] PC_MASK_OFS = 8'h10; // first of four group masks, 4 apart
	localparam logic [7:0] STATUS_OFS = 8'h20; // read-only block state
	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int UNLOCK_BIT = 0; // vector change unlock
	localparam int SELECT_BIT = 1; // vector base select
	localparam int EXT_BIT = 0; // external pin enable and flag
	localparam int GROUP_LSB = 4; // group enables and flags, bits 7..4
	localparam logic [7:0] REG_RESET = 8'h00; // every writable register clears at reset
	// ----------------------------------------
	// sense encodings
	// ----------------------------------------
	localparam logic [1:0] SENSE_LOW = 2'h0; // low level
	localparam logic [1:0] SENSE_ANY = 2'h1; // any change
	localparam logic [1:0] SENSE_FALL = 2'h2; // falling edge
	localparam logic [1:0] SENSE_RISE = 2'h3; // rising edge
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 5; // 200 MHz system clock
	localparam int UNLOCK_CYC = 4; // unlock window in cycles
	localparam logic [2:0] UNLOCK_LAST = 3'(UNLOCK_CYC - 1); // count at which unlock ends
	localparam int STARTUP_UNIT_NS = 80; // start-up step per fuse unit
	localparam int STARTUP_UNIT_CYC = (STARTUP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ----------------------------------------
	// vector table
	// ----------------------------------------
	localparam logic [15:0] FLASH_WORDS = 16'h4000; // flash size in words
	localparam logic [15:0] BOOT_WORDS_MAX = 16'h0800; // 4K-byte boot section, fuse 00
	localparam logic [15:0] VEC_STEP = 16'h0002; // words between vectors
	localparam logic [4:0] VEC_EXT = 5'h01; // vector numbers, zero based
	localparam logic [4:0] VEC_PC0 = 5'h02;
	localparam logic [4:0] VEC_PC1 = 5'h03;
	localparam logic [4:0] VEC_PC2 = 5'h17;
	localparam logic [4:0] VEC_PC3 = 5'h18;
	localparam logic [1:0] AXI_OKAY = 2'h0; // bus responses
	localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

/* File: verilog/vector_irq_ctrl.sv */
// Function
// R1 - select zero: flash start; one: boot section
// R2 - boot section start from boot size fuses
// R3 - software: unlock, then select within four cycles
// R4 - suppress from unlock until following instruction ends
// R5 - no select write: suppress four cycles only
// R6 - global interrupt enable left untouched
// R7 - unlock clears after four cycles or select write
// R8 - select changes only while unlock set
// R9 - boot vectors, app lock: block in application
// R10 - app vectors, boot lock: block in boot
// R11 - pins trigger even when driven as outputs
// R12 - group toggles request per enabled pin group
// R13 - four masks choose contributing pins
// R14 - pin changes detected without the I/O clock
// R15 - external pin: falling, rising or low level
// R16 - low level requests continuously while low
// R17 - edges recognised only with I/O clock
// R18 - low level detected without I/O clock
// R19 - I/O clock stops in non-idle sleep
// R20 - level must outlast start-up to interrupt
// R21 - start-up length from start-up and clock fuses
// R22 - 4K boot: relocated base 0x3800, vectors two apart
// R23 - boot reset fuse moves reset address
// R24 - relocated vector is default plus boot start
// R25 - sense field: low, any, falling, rising
// R26 - flags clear by vector or write one
// R27 - window counter restarts on each unlock write
`timescale 1ns/1ps
module vector_irq_ctrl
	import vec_irq_pkg::*;
(
	input wire logic MCLK, // system clock
	input wire logic RST_B, // synchronous reset, active low
	input wire logic [7:0] S_AXI_AWADDR, // write address
	input wire logic S_AXI_AWVALID, // write address valid
	output logic S_AXI_AWREADY, // write address ready
	input wire logic [31:0] S_AXI_WDATA, // write data
	input wire logic [3:0] S_AXI_WSTRB, // write strobes
	input wire logic S_AXI_WVALID, // write data valid
	output logic S_AXI_WREADY, // write data ready
	output logic [1:0] S_AXI_BRESP, // write response
	output logic S_AXI_BVALID, // write response valid
	input wire logic S_AXI_BREADY, // write response ready
	input wire logic [7:0] S_AXI_ARADDR, // read address
	input wire logic S_AXI_ARVALID, // read address valid
	output logic S_AXI_ARREADY, // read address ready
	output logic [31:0] S_AXI_RDATA, // read data
	output logic [1:0] S_AXI_RRESP, // read response
	output logic S_AXI_RVALID, // read data valid
	input wire logic S_AXI_RREADY, // read data ready
	input wire logic BOOT_RESET_FUSE_B, // boot reset fuse, low when programmed
	input wire logic [1:0] BOOT_SIZE_FUSES, // boot size fuses
	input wire logic [1:0] STARTUP_TIME_FUSES, // start-up time fuses
	input wire logic [1:0] CLOCK_SELECT_FUSES, // clock select fuses
	input wire logic APP_SIDE_BOOT_LOCK_B, // application lock, low when programmed
	input wire logic BOOT_SIDE_BOOT_LOCK_B, // boot lock, low when programmed
	input wire logic EXEC_IN_BOOT, // cpu executes from boot section
	input wire logic INSTR_DONE, // cpu instruction completes
	input wire logic SLEEP_ACTIVE, // cpu is asleep
	input wire logic SLEEP_IDLE, // the sleep mode is idle
	input wire logic [4:0] VECTOR_ACK, // one-hot: vector taken (ext, group 0..3)
	input wire logic EXT_IRQ_PIN, // external interrupt pin
	input wire logic [30:0] PIN_CHANGE_INPUTS, // pin change pins
	output logic [4:0] IRQ_REQ, // requests: ext, group 0..3
	output logic IRQ_BLOCK, // interrupt servicing suppressed
	output logic [15:0] VECTOR_BASE, // vector table base word address
	output logic [15:0] VECTOR_ADDR, // vector of highest pending request
	output logic [15:0] RESET_ADDR, // reset word address
	output logic IO_CLK_RUN, // i/o clock running
	output logic WAKE_REQ, // wake-up request
	output logic STARTUP_BUSY // wake-up start-up in progress
);
	import vec_irq_pkg::*;
	// ----------------------------------------
	// register state
	// ----------------------------------------
	logic select_reg; // vector base select
	logic unlock_reg; // vector change unlock
	logic [2:0] unlock_cnt_reg; // cycles since unlock write
	logic hold_reg; // suppression until next instruction ends
	logic [1:0] sense_reg; // sense field
	logic [7:0] enable_reg; // enables
	logic ext_flag_reg; // external flag
	logic [3:0] pc_flag_reg; // group flags
	logic [7:0] mask_reg [4]; // group masks
	logic [15:0] startup_cnt_reg; // start-up countdown
	// ----------------------------------------
	// bus slave state
	// ----------------------------------------
	logic aw_got_reg; // write address held
	logic w_got_reg; // write data held
	logic [7:0] aw_addr_reg; // held write address
	logic [7:0] w_data_reg; // held write byte
	logic w_strb_reg; // held strobe of byte 0
	logic wr_go; // write commits this cycle
	assign wr_go = aw_got_reg && w_got_reg && !S_AXI_BVALID;
	// write slave: take address and data in either order, answer after both
	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 8'h00;
			w_strb_reg <= 1'b0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= AXI_OKAY;
		end
		else
		begin
			S_AXI_AWREADY <= !aw_got_reg && !S_AXI_AWREADY && !S_AXI_BVALID;
			S_AXI_WREADY <= !w_got_reg && !S_AXI_WREADY && !S_AXI_BVALID;
			if (S_AXI_AWVALID && S_AXI_AWREADY)
			begin
				aw_got_reg <= 1'b1;
				aw_addr_reg <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY)
			begin
				w_got_reg <= 1'b1;
				w_data_reg <= S_AXI_WDATA[7:0];
				w_strb_reg <= S_AXI_WSTRB[0];
			end
			if (wr_go)
			begin
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= (aw_addr_reg <= STATUS_OFS && aw_addr_reg[1:0] == 2'h0) ? AXI_OKAY : AXI_SLVERR;
			end
			else if (S_AXI_BREADY)
				S_AXI_BVALID <= 1'b0;
		end
	end
	// byte write enables per register
	logic wr_ok;
	assign wr_ok = wr_go && w_strb_reg;
	logic wr_ctl;
	assign wr_ctl = wr_ok && aw_addr_reg == CPU_CONTROL_OFS;
	// ----------------------------------------
	// vector relocation unlock
	// ----------------------------------------
	logic unlock_next;
	logic hold_next;
	logic lock_block;
	always_comb
	begin
		unlock_next = unlock_reg;
		hold_next = hold_reg;
		// R7 - timed unlock clear
		if (unlock_reg && unlock_cnt_reg == UNLOCK_LAST)
			unlock_next = 1'b0;
		// R4 - hold ends after next instruction
		if (INSTR_DONE)
			hold_next = 1'b0;
		if (wr_ctl && w_data_reg[UNLOCK_BIT])
			unlock_next = 1'b1;
		else if (wr_ctl && unlock_reg)
		begin
			unlock_next = 1'b0;
			hold_next = 1'b1;
		end
	end
	// unlock, window count and select update
	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			select_reg <= 1'b0;
			unlock_reg <= 1'b0;
			unlock_cnt_reg <= 3'h0;
			hold_reg <= 1'b0;
		end
		else
		begin
			unlock_reg <= unlock_next;
			hold_reg <= hold_next;
			// R27 - restart window count
			if (wr_ctl && w_data_reg[UNLOCK_BIT])
				unlock_cnt_reg <= 3'h0;
			else if (unlock_reg)
				unlock_cnt_reg <= unlock_cnt_reg + 3'h1;
			// R8 - select only inside window
			if (wr_ctl && !w_data_reg[UNLOCK_BIT] && unlock_reg)
				select_reg <= w_data_reg[SELECT_BIT];
		end
	end
	// R9 - block application side
	// R10 - block boot side
	assign lock_block = (select_reg && !APP_SIDE_BOOT_LOCK_B && !EXEC_IN_BOOT)
		|| (!select_reg && !BOOT_SIDE_BOOT_LOCK_B && EXEC_IN_BOOT);
	// R4 - suppression output; R5 - four cycles without select; R6 - no global enable here
	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
			IRQ_BLOCK <= 1'b0;
		else
			IRQ_BLOCK <= unlock_next || hold_next || lock_block;
	end
	// ----------------------------------------
	// vector addresses
	// ----------------------------------------
	logic [15:0] boot_start;
	// R2 - boot start from size fuses; R22 - 4K gives 0x3800
	assign boot_start = FLASH_WORDS - (BOOT_WORDS_MAX >> BOOT_SIZE_FUSES);
	logic [4:0] pend_vec;
	always_comb
	begin
		pend_vec = 5'h00;
		if (IRQ_REQ[4])
			pend_vec = VEC_PC3;
		if (IRQ_REQ[3])
			pend_vec = VEC_PC2;
		if (IRQ_REQ[2])
			pend_vec = VEC_PC1;
		if (IRQ_REQ[1])
			pend_vec = VEC_PC0;
		if (IRQ_REQ[0])
			pend_vec = VEC_EXT;
	end
	// R1 - base select; R24 - default plus boot start; R23 - reset address
	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			VECTOR_BASE <= 16'h0000;
			VECTOR_ADDR <= 16'h0000;
			RESET_ADDR <= 16'h0000;
		end
		else
		begin
			VECTOR_BASE <= select_reg ? boot_start : 16'h0000;
			VECTOR_ADDR <= (select_reg ? boot_start : 16'h0000) + VEC_STEP * 16'(pend_vec);
			RESET_ADDR <= BOOT_RESET_FUSE_B ? 16'h0000 : boot_start;
		end
	end
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [31:0] pin_s1_reg; // first stage, read only by second
	logic [31:0] pin_s2_reg; // synchronised pins, bit 31 is the external pin
	logic [31:0] pin_prev_reg; // previous synchronised value
	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			pin_s1_reg <= 32'hffffffff;
			pin_s2_reg <= 32'hffffffff;
			pin_prev_reg <= 32'hffffffff;
		end
		else
		begin
			// R11 - pins sampled whatever drives them
			pin_s1_reg <= {EXT_IRQ_PIN, PIN_CHANGE_INPUTS};
			pin_s2_reg <= pin_s1_reg;
			pin_prev_reg <= pin_s2_reg;
		end
	end
	// ----------------------------------------
	// external pin detection
	// ----------------------------------------
	logic io_run;
	// R19 - i/o clock stops in non-idle sleep
	assign io_run = !(SLEEP_ACTIVE && !SLEEP_IDLE);
	logic ext_now;
	logic ext_was;
	logic ext_edge;
	logic level_low;
	assign ext_now = pin_s2_reg[31];
	assign ext_was = pin_prev_reg[31];
	// R15 - sense decode; R25 - encoding
	always_comb
	begin
		case (sense_reg)
			SENSE_ANY: ext_edge = ext_now != ext_was;
			SENSE_FALL: ext_edge = ext_was && !ext_now;
			SENSE_RISE: ext_edge = !ext_was && ext_now;
			default: ext_edge = 1'b0;
		endcase
	end
	// R18 - level seen in any sleep mode
	assign level_low = sense_reg == SENSE_LOW && !ext_now;
	// ----------------------------------------
	// registers and flags
	// ----------------------------------------
	logic [3:0] pc_hit; // group change this cycle
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : gen_group
			// R12 - group toggle; R13 - mask; R14 - no i/o clock gate
			assign pc_hit[g] = |((pin_s2_reg[g*8 +: 8] ^ pin_prev_reg[g*8 +: 8]) & mask_reg[g] & (g == 3 ? 8'h7f : 8'hff));
		end
	endgenerate
	logic flag_clr_ok;
	assign flag_clr_ok = wr_ok && aw_addr_reg == FLAG_OFS;
	// software registers and sticky flags, a set beats a clear
	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			sense_reg <= 2'h0;
			enable_reg <= REG_RESET;
			ext_flag_reg <= 1'b0;
			pc_flag_reg <= 4'h0;
			for (int i = 0; i < 4; i++)
				mask_reg[i] <= REG_RESET;
		end
		else
		begin
			if (wr_ok && aw_addr_reg == SENSE_OFS)
				sense_reg <= w_data_reg[1:0];
			if (wr_ok && aw_addr_reg == ENABLE_OFS)
				enable_reg <= w_data_reg & 8'hf1;
			for (int i = 0; i < 4; i++)
				if (wr_ok && aw_addr_reg == PC_MASK_OFS + 8'(4 * i))
					mask_reg[i] <= w_data_reg;
			// R26 - flag clear by vector or write one; R17 - edges need i/o clock
			if (sense_reg == SENSE_LOW)
				ext_flag_reg <= 1'b0;
			else if (ext_edge && io_run)
				ext_flag_reg <= 1'b1;
			else if (VECTOR_ACK[0] || (flag_clr_ok && w_data_reg[EXT_BIT]))
				ext_flag_reg <= 1'b0;
			for (int i = 0; i < 4; i++)
				if (pc_hit[i])
					pc_flag_reg[i] <= 1'b1;
				else if (VECTOR_ACK[i+1] || (flag_clr_ok && w_data_reg[GROUP_LSB+i]))
					pc_flag_reg[i] <= 1'b0;
		end
	end
	// ----------------------------------------
	// wake-up and start-up
	// ----------------------------------------
	logic [15:0] startup_len;
	// R21 - length from start-up and clock fuses
	assign startup_len = 16'(STARTUP_UNIT_CYC * (STARTUP_TIME_FUSES + 1) * (CLOCK_SELECT_FUSES + 1));
	logic wake_src;
	assign wake_src = (level_low && enable_reg[EXT_BIT]) || (ext_flag_reg && enable_reg[EXT_BIT])
		|| |(pc_flag_reg & enable_reg[GROUP_LSB +: 4]);
	// start-up countdown on a wake from non-idle sleep
	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			startup_cnt_reg <= 16'h0000;
			WAKE_REQ <= 1'b0;
			STARTUP_BUSY <= 1'b0;
			IO_CLK_RUN <= 1'b1;
		end
		else
		begin
			WAKE_REQ <= SLEEP_ACTIVE && wake_src;
			IO_CLK_RUN <= io_run;
			if (SLEEP_ACTIVE && !SLEEP_IDLE && wake_src && startup_cnt_reg == 16'h0000)
				startup_cnt_reg <= startup_len;
			else if (startup_cnt_reg != 16'h0000)
				startup_cnt_reg <= startup_cnt_reg - 16'h0001;
			STARTUP_BUSY <= startup_cnt_reg > 16'h0001;
		end
	end
	// ----------------------------------------
	// requests to the cpu
	// ----------------------------------------
	// R16 - continuous level request; R20 - level ignored until start-up ends
	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
			IRQ_REQ <= 5'h00;
		else
			IRQ_REQ <= {pc_flag_reg & enable_reg[GROUP_LSB +: 4],
				enable_reg[EXT_BIT] && (ext_flag_reg || (level_low && startup_cnt_reg == 16'h0000))};
	end
	// ----------------------------------------
	// read slave
	// ----------------------------------------
	logic [7:0] rd_byte;
	always_comb
	begin
		case (S_AXI_ARADDR)
			CPU_CONTROL_OFS: rd_byte = {6'h00, select_reg, unlock_reg};
			SENSE_OFS: rd_byte = {6'h00, sense_reg};
			ENABLE_OFS: rd_byte = enable_reg;
			FLAG_OFS: rd_byte = {pc_flag_reg, 3'h0, ext_flag_reg};
			PC_MASK_OFS: rd_byte = mask_reg[0];
			PC_MASK_OFS + 8'h04: rd_byte = mask_reg[1];
			PC_MASK_OFS + 8'h08: rd_byte = mask_reg[2];
			PC_MASK_OFS + 8'h0c: rd_byte = mask_reg[3];
			STATUS_OFS: rd_byte = {4'h0, STARTUP_BUSY, IO_CLK_RUN, lock_block, unlock_reg || hold_reg};
			default: rd_byte = 8'h00;
		endcase
	end
	// one read at a time, answered the cycle after the address is taken
	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= AXI_OKAY;
		end
		else
		begin
			S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
			if (S_AXI_ARVALID && S_AXI_ARREADY)
			begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= {24'h000000, rd_byte};
				S_AXI_RRESP <= (S_AXI_ARADDR <= STATUS_OFS && S_AXI_ARADDR[1:0] == 2'h0) ? AXI_OKAY : AXI_SLVERR;
			end
			else if (S_AXI_RREADY)
				S_AXI_RVALID <= 1'b0;
		end
	end
	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_B);
	property p_unlock_four;
		$rose(unlock_reg) ##0 (!wr_ctl) [*4] |=> !unlock_reg;
	endproperty
	a_unlock_four: assert property (p_unlock_four) else $error("unlock outlived its window"); // R7
	property p_select_guard;
		!unlock_reg |=> $stable(select_reg);
	endproperty
	a_select_guard: assert property (p_select_guard) else $error("select changed without unlock"); // R8
	property p_block_on_unlock;
		$rose(unlock_reg) |=> IRQ_BLOCK;
	endproperty
	a_block_on_unlock: assert property (p_block_on_unlock) else $error("no suppression after unlock"); // R4
	property p_block_ends;
		$rose(unlock_reg) ##0 (!wr_ctl && !hold_reg && !lock_block) [*4] |=> !IRQ_BLOCK;
	endproperty
	a_block_ends: assert property (p_block_ends) else $error("suppression did not end"); // R5
	property p_level_flag;
		sense_reg == SENSE_LOW |=> !ext_flag_reg;
	endproperty
	a_level_flag: assert property (p_level_flag) else $error("flag set in level mode"); // R26
	property p_edge_gated;
		!io_run && ext_edge && !ext_flag_reg |=> !ext_flag_reg;
	endproperty
	a_edge_gated: assert property (p_edge_gated) else $error("edge seen without i/o clock"); // R17
	property p_group_set;
		pc_hit[1] |=> pc_flag_reg[1];
	endproperty
	a_group_set: assert property (p_group_set) else $error("group change lost"); // R12
	property p_base;
		select_reg && $stable(select_reg) && $stable(BOOT_SIZE_FUSES) |=> VECTOR_BASE == $past(boot_start);
	endproperty
	a_base: assert property (p_base) else $error("wrong vector base"); // R1
	property p_level_req;
		level_low && enable_reg[EXT_BIT] && startup_cnt_reg == 16'h0000 |=> IRQ_REQ[0];
	endproperty
	a_level_req: assert property (p_level_req) else $error("level request missing"); // R16
	c_unlock_select: cover property (wr_ctl && unlock_reg && !w_data_reg[UNLOCK_BIT]);
	c_unlock_expire: cover property ($fell(unlock_reg) && !hold_reg);
	c_pc_request: cover property (IRQ_REQ[2]);
	c_wake: cover property (STARTUP_BUSY ##1 !STARTUP_BUSY);
endmodule

/* File: testbench/pin_partner.sv */
`timescale 1ns/1ps
// ----------------------------------------
// outside logic that drives the interrupt pins
// ----------------------------------------
module pin_partner
(
	input wire logic clk, // system clock
	output logic ext_pin, // external interrupt pin
	output logic [30:0] pc_pins // pin change pins
);
	// pins rest high through pull-ups
	initial
	begin
		ext_pin = 1'b1;
		pc_pins = '1;
	end
	// drive and hold level
	// waits slow + 1 rising edges, then drives just after the last and holds until the next call
	task automatic drive(input logic e, input logic [30:0] p, input int slow);
		repeat (slow + 1) @(posedge clk);
		ext_pin <= e;
		pc_pins <= p;
	endtask
endmodule

/* File: testbench/vector_relocation_and_ext_irq_tb.sv */
`timescale 1ns/1ps
// compares one value, counts it and reports a mismatch
`define CHK(nm, ex, got) \
	begin n_compared++; if ((got) !== (ex)) begin n_mismatch++; \
	$display("unexpected %s: expected %h, seen %h", nm, ex, got); end end
module vector_relocation_and_ext_irq_tb;
	import vec_irq_pkg::*;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic mclk = 0, rst_b = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic [1:0] bresp, rresp, boot_size = 0, startup_time_fuses = 0, cks = 0;
	logic boot_rst_b = 1, app_lock_b = 1, boot_lock_b = 1, exec_boot = 0, instr_done = 0;
	logic sleep = 0, sleep_idle = 0, ext_pin, awready, wready, bvalid, arready, rvalid;
	logic irq_block, io_run, wake, su_busy;
	logic [4:0] ack = 0, irq_req;
	logic [30:0] pc, pcv = '1;
	logic [15:0] vbase, vaddr, raddr;
	logic [1:0] wq[$], eb; // expected write responses
	logic [33:0] rq[$], er; // expected read responses and words
	logic [6:0] row; // sense, from, to, sleep, idle, expect
	logic [6:0] ext_tab [6] = '{7'h51, 7'h69, 7'h70, 7'h31, 7'h54, 7'h57};
	int n_mismatch = 0, n_compared = 0, cyc = 0, seed = 74078, i;
	always #(CLK_PERIOD_NS / 2.0) mclk = ~mclk;
	vector_irq_ctrl i_dut (.MCLK(mclk), .RST_B(rst_b), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .BOOT_RESET_FUSE_B(boot_rst_b),
		.BOOT_SIZE_FUSES(boot_size), .STARTUP_TIME_FUSES(startup_time_fuses), .CLOCK_SELECT_FUSES(cks),
		.APP_SIDE_BOOT_LOCK_B(app_lock_b), .BOOT_SIDE_BOOT_LOCK_B(boot_lock_b), .EXEC_IN_BOOT(exec_boot),
		.INSTR_DONE(instr_done), .SLEEP_ACTIVE(sleep), .SLEEP_IDLE(sleep_idle), .VECTOR_ACK(ack),
		.EXT_IRQ_PIN(ext_pin), .PIN_CHANGE_INPUTS(pc), .IRQ_REQ(irq_req), .IRQ_BLOCK(irq_block),
		.VECTOR_BASE(vbase), .VECTOR_ADDR(vaddr), .RESET_ADDR(raddr), .IO_CLK_RUN(io_run),
		.WAKE_REQ(wake), .STARTUP_BUSY(su_busy));
	pin_partner i_pins (.clk(mclk), .ext_pin(ext_pin), .pc_pins(pc));
	// ----------------------------------------
	// response watcher and hang limit
	// ----------------------------------------
	// takes the oldest note whenever a bus answer is handed over
	always @(posedge mclk)
	begin
		if (bvalid === 1'b1 && bready === 1'b1)
		begin
			eb = wq.pop_front();
			`CHK("write response", eb, bresp)
		end
		if (rvalid === 1'b1 && rready === 1'b1)
		begin
			er = rq.pop_front();
			`CHK("read word", er, {rresp, rdata})
		end
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			results();
		end
	end
	// ----------------------------------------
	// bus and helper tasks
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// write one byte, both channels offered together and released when taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		wq.push_back(r);
		@(posedge mclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw && w))
		begin
			@(posedge mclk);
			if (awready === 1'b1) aw = 1'b1;
			if (wready === 1'b1) w = 1'b1;
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
		end
		do @(posedge mclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask
	// read one word and note the low byte expected
	task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
		rq.push_back({r, 24'h0, d});
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge mclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge mclk); while (rvalid !== 1'b1);
		rready <= 1'b0;
	endtask
	// unlock, load the select bit, then end the hold with one instruction
	task automatic relocate(input logic s);
		wr(CPU_CONTROL_OFS, 8'h01, AXI_OKAY);
		`CHK("block on unlock", 1'b1, irq_block)
		wr(CPU_CONTROL_OFS, {6'h0, s, 1'b0}, AXI_OKAY);
		tick(6);
		`CHK("block held", 1'b1, irq_block)
		instr_done <= 1'b1;
		tick(1);
		instr_done <= 1'b0;
		tick(2);
		`CHK("block released", 1'b0, irq_block)
		rd(CPU_CONTROL_OFS, {6'h0, s, 1'b0}, AXI_OKAY);
	endtask
	task automatic results();
		$display("compared %0d, mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		tick(2);
		rst_b <= 1'b1;
		startup_time_fuses <= 2'($random(seed));
		cks <= 2'($random(seed));
		// reset values, unmapped places and a locked select write
		for (i = 0; i < 8; i++) rd(8'(i * 4), REG_RESET, AXI_OKAY);
		rd(STATUS_OFS, 8'h04, AXI_OKAY);
		rd(8'h40, 8'h00, AXI_SLVERR);
		wr(8'h44, 8'h01, AXI_SLVERR);
		wr(CPU_CONTROL_OFS, 8'h02, AXI_OKAY);
		rd(CPU_CONTROL_OFS, 8'h00, AXI_OKAY);
		`CHK("flash base", 16'h0000, vbase)
		`CHK("plain reset address", 16'h0000, raddr)
		$display("test reset done");
		relocate(1'b1);
		`CHK("boot base", 16'(FLASH_WORDS - BOOT_WORDS_MAX), vbase)
		wr(CPU_CONTROL_OFS, 8'h01, AXI_OKAY);
		`CHK("block on lone unlock", 1'b1, irq_block)
		tick(6);
		`CHK("block after window", 1'b0, irq_block)
		rd(CPU_CONTROL_OFS, 8'h02, AXI_OKAY);
		boot_rst_b <= 1'b0;
		for (i = 0; i < 4; i++)
		begin
			boot_size <= 2'(i);
			tick(3);
			`CHK("fuse base", 16'(FLASH_WORDS - (BOOT_WORDS_MAX >> i)), vbase)
			`CHK("boot reset address", 16'(FLASH_WORDS - (BOOT_WORDS_MAX >> i)), raddr)
		end
		boot_size <= 2'h0;
		$display("test relocation done");
		// external pin senses, with and without the i/o clock
		wr(ENABLE_OFS, 8'h01, AXI_OKAY);
		for (i = 0; i < 6; i++)
		begin
			row = ext_tab[i];
			i_pins.drive(row[4], pcv, 0);
			tick(6);
			wr(SENSE_OFS, {6'h0, row[6:5]}, AXI_OKAY);
			wr(FLAG_OFS, 8'h01, AXI_OKAY);
			sleep <= row[2];
			sleep_idle <= row[1];
			i_pins.drive(row[3], pcv, 2);
			tick(8);
			sleep <= 1'b0;
			tick(300);
			`CHK("edge request", row[0], irq_req[0])
			if (row[0])
			begin
				`CHK("ext vector", 16'(FLASH_WORDS - BOOT_WORDS_MAX + VEC_STEP * VEC_EXT), vaddr)
				ack <= 5'h01;
				tick(1);
				ack <= 5'h00;
				tick(3);
				`CHK("acked request", 1'b0, irq_req[0])
			end
		end
		// low level keeps requesting and wakes from deep sleep
		wr(SENSE_OFS, {6'h0, SENSE_LOW}, AXI_OKAY);
		sleep <= 1'b1;
		sleep_idle <= 1'b0;
		tick(6);
		`CHK("level wake", 1'b1, wake)
		`CHK("io clock stopped", 1'b0, io_run)
		`CHK("start-up busy", 1'b1, su_busy)
		`CHK("level held off", 1'b0, irq_req[0])
		sleep <= 1'b0;
		tick(300);
		`CHK("start-up over", 1'b0, su_busy)
		`CHK("level request", 1'b1, irq_req[0])
		rd(FLAG_OFS, 8'h00, AXI_OKAY);
		`CHK("level still requests", 1'b1, irq_req[0])
		i_pins.drive(1'b1, pcv, 0);
		tick(6);
		`CHK("level gone", 1'b0, irq_req[0])
		$display("test external pin done");
		// pin change groups: masked pins ignored, enabled pin wakes and requests
		wr(ENABLE_OFS, 8'h30, AXI_OKAY);
		wr(8'(PC_MASK_OFS + 8'h04), 8'h01, AXI_OKAY);
		wr(FLAG_OFS, 8'hf0, AXI_OKAY);
		for (i = 0; i < 4; i++)
		begin
			pcv = pcv ^ (31'($random(seed)) & 31'h7ffffeff);
			i_pins.drive(1'b1, pcv, 0);
			tick(8);
			`CHK("masked pins", 4'h0, irq_req[4:1])
		end
		sleep <= 1'b1;
		pcv = pcv ^ 31'h100;
		i_pins.drive(1'b1, pcv, 2);
		tick(8);
		`CHK("pin change wake", 1'b1, wake)
		sleep <= 1'b0;
		tick(300);
		`CHK("group requests", 4'h2, irq_req[4:1])
		`CHK("group vector", 16'(FLASH_WORDS - BOOT_WORDS_MAX + VEC_STEP * VEC_PC1), vaddr)
		ack <= 5'h04;
		tick(1);
		ack <= 5'h00;
		tick(3);
		`CHK("acked group", 4'h0, irq_req[4:1])
		$display("test pin change done");
		// boot lock bits block servicing per executing section
		app_lock_b <= 1'b0;
		tick(3);
		`CHK("app lock block", 1'b1, irq_block)
		exec_boot <= 1'b1;
		tick(3);
		`CHK("app lock in boot", 1'b0, irq_block)
		app_lock_b <= 1'b1;
		exec_boot <= 1'b0;
		relocate(1'b0);
		boot_lock_b <= 1'b0;
		exec_boot <= 1'b1;
		tick(3);
		`CHK("boot lock block", 1'b1, irq_block)
		exec_boot <= 1'b0;
		tick(3);
		`CHK("boot lock in app", 1'b0, irq_block)
		$display("test lock done");
		results();
	end
endmodule
